// File: include/codec_port_pkg.sv
// constants for the codec parallel register port controller
package codec_port_pkg;
  // ****************************************
  // clock and pin timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SETUP_NS = 22;
  localparam int unsigned STROBE_NS = 90;
  localparam int unsigned HOLD_NS = 15;
  localparam int unsigned GAP_NS = 80;
  // least times round up
  localparam int unsigned SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 8;
  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] WDATA_OFS = 8'h04;
  localparam logic [7:0] RDATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] CTRL_OFS = 8'h10;
  localparam logic [7:0] TIMING_OFS = 8'h14;
  // cmd fields
  localparam int unsigned CMD_ADDR_LSB = 0;
  localparam int unsigned CMD_ADDR_W = 2;
  localparam int unsigned CMD_WRITE_BIT = 8;
  // ctrl fields
  localparam int unsigned CTRL_PDN_BIT = 0;
  // timing fields: extra wait-states per strobe, added to the strobe count
  localparam int unsigned TIM_EXTRA_LSB = 0;
  localparam logic [7:0] TIM_EXTRA_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 2;
endpackage

// File: rtl/codec_access_seq.sv
// pacing engine: setup, strobe, hold and gap phases for one codec access
module codec_access_seq
  import codec_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic write,
  input wire logic [CNT_W-1:0] extra,
  input wire logic ready_sync,
  output logic cs_n_q,
  output logic rd_n_q,
  output logic wr_n_q,
  output logic drive_q,
  output logic capture,
  output logic busy
);
  typedef enum logic [2:0] {IDLE, SETUP, STROBE, WAITRDY, HOLD, GAP} seq_t;
  seq_t state_q;
  logic [CNT_W-1:0] cnt_q;

  assign busy = (state_q != IDLE);
  assign capture = (state_q == WAITRDY) && ready_sync && !write;

  // ****************************************
  // phase sequencer
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= IDLE;
      cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        IDLE:
        begin
          if (start)
          begin
            state_q <= SETUP;
            cnt_q <= CNT_W'(SETUP_CYC - 1);
          end
        end
        // RQ12 setup before strobe
        SETUP:
        begin
          if (cnt_q == '0)
          begin
            state_q <= STROBE;
            cnt_q <= CNT_W'(STROBE_CYC - 1) + extra;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        // RQ13 minimum strobe width
        STROBE:
        begin
          if (cnt_q == '0)
            state_q <= WAITRDY;
          else
            cnt_q <= cnt_q - 1'b1;
        end
        // RQ6 ready stretches the strobe
        WAITRDY:
        begin
          if (ready_sync)
          begin
            state_q <= HOLD;
            cnt_q <= CNT_W'(HOLD_CYC - 1);
          end
        end
        // RQ1 data held through hold
        HOLD:
        begin
          if (cnt_q == '0)
          begin
            state_q <= GAP;
            cnt_q <= CNT_W'(GAP_CYC - HOLD_CYC - 1);
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        // RQ3 gap between strobes
        GAP:
        begin
          if (cnt_q == '0)
            state_q <= IDLE;
          else
            cnt_q <= cnt_q - 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      drive_q <= 1'b0;
    end
    else
    begin
      cs_n_q <= !((state_q == IDLE && start) || state_q == SETUP || state_q == STROBE || state_q == WAITRDY
                  || state_q == HOLD);
      rd_n_q <= !(!write && ((state_q == SETUP && cnt_q == '0) || state_q == STROBE
                  || (state_q == WAITRDY && !ready_sync)));
      wr_n_q <= !(write && ((state_q == SETUP && cnt_q == '0) || state_q == STROBE
                  || (state_q == WAITRDY && !ready_sync)));
      // RQ1 data valid from cycle start
      drive_q <= write && ((state_q == IDLE && start) || (state_q != IDLE && state_q != GAP
                 && !(state_q == HOLD && cnt_q == '0)));
    end
  end
endmodule

// File: rtl/codec_port_ctrl.sv
// axi4-lite controlled host for the codec parallel register port
// Operation
// RQ1 - write data stays valid from cycle start through hold of at least 15 ns
// RQ2 - hold phase covers write data and address hold at the clock rate
// RQ3 - at least 80 ns from strobe rising edge to next falling edge
// RQ4 - gap may be met by longer setup and strobe phases
// RQ5 - software may space accesses itself; hardware pacing also enforced
// RQ6 - shared space: logic shapes strobes and ready extends accesses
// RQ7 - differing devices resolved by stretching through the ready handshake
// RQ8 - codec interrupt output is wired to a host interrupt input
// RQ9 - codec has an on-chip timer for timing or watchdog use
// RQ10 - asserting active-low power-down puts codec in low-power mode
// RQ11 - two general-purpose codec outputs follow the pin control register
// RQ12 - setup phase meets the 22 ns address setup
// RQ13 - strobe phase lasts at least 90 ns; the 8-bit strobe count wraps, so timing extra 248 to 254 allows 20 to 80 ns
module codec_port_ctrl
  import codec_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic codec_space_select_n,
  output logic codec_rd_n,
  output logic codec_wr_n,
  output logic [ADDR_W-1:0] codec_addr,
  output logic [DATA_W-1:0] codec_data_o,
  output logic codec_data_oe_n,
  input wire logic [DATA_W-1:0] codec_data_i,
  input wire logic async_ready_in,
  input wire logic codec_irq,
  output logic power_down_n,
  output logic irq_out
);
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic write_q;
  logic pend_q;
  logic done_q;
  logic [CNT_W-1:0] extra_q;
  logic pdn_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] wbyte_q;
  logic [ADDR_W-1:0] addr_q;
  logic [1:0] rdy_s_q, irq_s_q;
  logic start, capture, busy, drive_q;
  logic wr_fire;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdy_s_q <= 2'b00;
      irq_s_q <= 2'b00;
    end
    else
    begin
      rdy_s_q <= {rdy_s_q[0], async_ready_in};
      irq_s_q <= {irq_s_q[0], codec_irq};
    end
  end

  // RQ8 interrupt passed to host
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_out <= 1'b0;
    else
      irq_out <= irq_s_q[1];
  end

  // ****************************************
  // axi write channel
  // ****************************************
  assign wr_fire = aw_q && w_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      // a codec command waits while the port is still pacing
      if (wr_fire && !(awaddr_q == CMD_OFS && (pend_q || busy)))
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == CMD_OFS || awaddr_q == WDATA_OFS || awaddr_q == CTRL_OFS
                        || awaddr_q == TIMING_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pdn_q <= 1'b0;
      extra_q <= TIM_EXTRA_RST;
      wbyte_q <= '0;
      addr_q <= '0;
      write_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      pend_q <= 1'b0;
      if (wr_fire && !s_axi_bvalid && wstrb_q[0])
      begin
        unique case (awaddr_q)
          CTRL_OFS: pdn_q <= wdata_q[CTRL_PDN_BIT];
          // RQ7 per-space extra wait-states
          TIMING_OFS: extra_q <= wdata_q[TIM_EXTRA_LSB +: CNT_W];
          WDATA_OFS: wbyte_q <= wdata_q[DATA_W-1:0];
          CMD_OFS:
          begin
            if (!busy && !pend_q)
            begin
              addr_q <= wdata_q[CMD_ADDR_LSB +: CMD_ADDR_W];
              write_q <= wdata_q[CMD_WRITE_BIT];
              pend_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end
  assign start = pend_q;

  // RQ10 power-down pin from control bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      power_down_n <= 1'b1;
    else
      power_down_n <= !pdn_q;
  end

  // ****************************************
  // codec address and data pins
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      codec_addr <= '0;
      codec_data_o <= '0;
      done_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      // RQ2 address held through hold phase
      if (start)
        codec_addr <= addr_q;
      if (start)
        codec_data_o <= wbyte_q;
      if (capture)
        rdata_q <= codec_data_i;
      // a new access clears done; an idle engine sets it again
      if (start)
        done_q <= 1'b0;
      else if (!busy)
        done_q <= 1'b1;
    end
  end
  assign codec_data_oe_n = !drive_q;

  // RQ4 RQ5 RQ13 pacing engine
  codec_access_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start),
    .write(write_q),
    .extra(extra_q),
    .ready_sync(rdy_s_q[1]),
    .cs_n_q(codec_space_select_n),
    .rd_n_q(codec_rd_n),
    .wr_n_q(codec_wr_n),
    .drive_q(drive_q),
    .capture(capture),
    .busy(busy)
  );

  // ****************************************
  // axi read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        CMD_OFS: s_axi_rdata <= {23'h0, write_q, 6'h0, addr_q};
        WDATA_OFS: s_axi_rdata <= {24'h0, wbyte_q};
        RDATA_OFS: s_axi_rdata <= {24'h0, rdata_q};
        STATUS_OFS: s_axi_rdata <= {29'h0, irq_s_q[1], done_q, busy | pend_q};
        CTRL_OFS: s_axi_rdata <= {31'h0, pdn_q};
        TIMING_OFS: s_axi_rdata <= {24'h0, extra_q};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// File: testbench/codec_port_checker.sv
// pin and bus timing assertions for the codec port controller
module codec_port_checker
  import codec_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic codec_space_select_n,
  input wire logic codec_rd_n,
  input wire logic codec_wr_n,
  input wire logic [ADDR_W-1:0] codec_addr,
  input wire logic [DATA_W-1:0] codec_data_o,
  input wire logic codec_data_oe_n,
  input wire logic async_ready_in,
  input wire logic codec_irq,
  input wire logic irq_out,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic idle_n = codec_rd_n & codec_wr_n;
  property p_setup; $fell(idle_n) |-> !$past(codec_space_select_n, 3); endproperty
  a_setup: assert property (p_setup) else $error("setup short");
  property p_rd_len; $fell(codec_rd_n) |-> ##1 !codec_rd_n [*8]; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe short");
  property p_wr_len; $fell(codec_wr_n) |-> ##1 !codec_wr_n [*8]; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe short");
  property p_hold;
    $rose(codec_wr_n) |-> (!codec_data_oe_n && !codec_space_select_n && $stable(codec_data_o)
      && $stable(codec_addr)) [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("hold short");
  property p_drive; !codec_wr_n |-> !codec_data_oe_n && $stable(codec_data_o); endproperty
  a_drive: assert property (p_drive) else $error("write data not held");
  property p_gap; $rose(idle_n) |-> idle_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("strobe gap short");
  property p_ready; (!async_ready_in [*4]) ##0 !idle_n |=> !idle_n; endproperty
  a_ready: assert property (p_ready) else $error("strobe ended without ready");
  property p_irq; codec_irq [*4] |-> irq_out; endproperty
  a_irq: assert property (p_irq) else $error("irq not passed");
  property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("read answer late");
  c_rd: cover property ($fell(codec_rd_n));
  c_wr: cover property ($fell(codec_wr_n));
  c_irq: cover property ($rose(irq_out));
endmodule

bind codec_port_ctrl codec_port_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .codec_space_select_n(codec_space_select_n), .codec_rd_n(codec_rd_n), .codec_wr_n(codec_wr_n),
  .codec_addr(codec_addr), .codec_data_o(codec_data_o), .codec_data_oe_n(codec_data_oe_n),
  .async_ready_in(async_ready_in), .codec_irq(codec_irq), .irq_out(irq_out),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// File: testbench/codec_model.sv
// behavioural codec register port with ready shaping
module codec_model (
  input wire logic aclk,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] din,
  input wire logic oe_n,
  output logic [7:0] dout,
  output logic ready,
  input wire logic slow,
  input wire logic irq_req,
  output logic irq,
  input wire logic pdn_n,
  output logic [1:0] gp_output_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs_q [3] = '{default: '0};
  logic [7:0] timer_q = '0;
  logic [7:0] last_q = '0;
  logic [4:0] lo_q = '0;
  always @(posedge wr_n)
    if (!cs_n && !oe_n && pdn_n && addr != 2'h3)
      regs_q[addr] <= din;
  assign gp_output_pins = regs_q[2][1:0];
  // released bus shows inverse of last byte
  assign dout = (!cs_n && !rd_n) ? ((addr == 2'h3) ? timer_q : regs_q[addr]) : ~last_q;
  always @(posedge aclk)
  begin
    if (pdn_n)
      timer_q <= timer_q + 8'h01;
    if (!cs_n && !rd_n)
      last_q <= dout;
    lo_q <= (rd_n & wr_n) ? 5'h00 : lo_q + 5'(lo_q != 5'h1f);
  end
  assign ready = !slow || lo_q >= 5'h0c;
  assign irq = irq_req && pdn_n;
endmodule

// File: testbench/test_codec_port_ctrl.sv
// self-checking bench for the codec port controller
module test_codec_port_ctrl
  import codec_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, slow = 0, irq_req = 0;
  logic [7:0] awaddr = '0, araddr = '0, len_q = '0, cnt_q = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, cs_n, rd_n, wr_n, oe_n, ready, irq, pdn_n, irq_out;
  logic [1:0] bresp, rresp, gp;
  logic [ADDR_W-1:0] caddr;
  logic [DATA_W-1:0] cdo, cdi;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  codec_port_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .codec_space_select_n(cs_n),
    .codec_rd_n(rd_n), .codec_wr_n(wr_n), .codec_addr(caddr), .codec_data_o(cdo), .codec_data_oe_n(oe_n),
    .codec_data_i(cdi), .async_ready_in(ready), .codec_irq(irq), .power_down_n(pdn_n), .irq_out(irq_out));
  codec_model u_codec (.aclk(aclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(caddr), .din(cdo),
    .oe_n(oe_n), .dout(cdi), .ready(ready), .slow(slow), .irq_req(irq_req), .irq(irq), .pdn_n(pdn_n),
    .gp_output_pins(gp));
  initial forever #5 aclk = ~aclk;
  // strobe length in cycles, plus hang guard
  always @(posedge aclk)
  begin
    cnt_q <= (rd_n & wr_n) ? 8'h00 : cnt_q + 8'h01;
    if ((rd_n & wr_n) && cnt_q != 8'h00)
      len_q <= cnt_q;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      stop_test;
    end
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    logic [1:0] r;
    axi_wr(WDATA_OFS, {24'h00_0000, d}, r);
    axi_wr(CMD_OFS, (32'(w) << CMD_WRITE_BIT) | 32'(a), r);
    do axi_rd(STATUS_OFS, s, r); while (s[0] !== 1'b0);
    chk("done", 32'(s[1]), 32'h0000_0001);
    axi_rd(RDATA_OFS, s, r);
    q = s[7:0];
  endtask
  task automatic t_basic;
    logic [31:0] s;
    logic [1:0] r;
    logic [7:0] q;
    chk("pins", 32'({cs_n, rd_n, wr_n, oe_n, pdn_n, irq_out}), 32'h0000_003e);
    axi_rd(TIMING_OFS, s, r);
    chk("timing", s, 32'(TIM_EXTRA_RST));
    // two commands back to back: second waits for pacing
    axi_wr(WDATA_OFS, 32'h0000_005a, r);
    axi_wr(CMD_OFS, 32'h0000_0100, r);
    axi_wr(CMD_OFS, 32'h0000_0101, r);
    acc(1'b0, 2'h1, 8'h00, q);
    chk("rd1", 32'(q), 32'h0000_005a);
    // strobe gets one more cycle while synchronised ready is sampled
    chk("rlen", 32'(len_q), 32'(STROBE_CYC + 1));
    acc(1'b1, 2'h1, 8'ha5, q);
    chk("wlen", 32'(len_q), 32'(STROBE_CYC + 1));
    acc(1'b0, 2'h1, 8'h00, q);
    chk("rd1b", 32'(q), 32'h0000_00a5);
    axi_wr(TIMING_OFS, 32'h0000_0003, r);
    acc(1'b0, 2'h0, 8'h00, q);
    chk("xlen", 32'(len_q), 32'(STROBE_CYC + 3 + 1));
    axi_wr(TIMING_OFS, 32'h0000_0000, r);
    slow <= 1'b1;
    acc(1'b0, 2'h0, 8'h00, q);
    chk("slow", 32'(q), 32'h0000_005a);
    chk("slen", 32'(len_q >= 8'h0d), 32'h0000_0001);
    slow <= 1'b0;
    $display("access tests done");
  endtask
  task automatic t_side;
    logic [31:0] s;
    logic [1:0] r;
    logic [7:0] q, q2;
    acc(1'b1, 2'h2, 8'h02, q);
    chk("gp", 32'(gp), 32'h0000_0002);
    acc(1'b0, 2'h3, 8'h00, q);
    acc(1'b0, 2'h3, 8'h00, q2);
    chk("timer", 32'(q2 != q), 32'h0000_0001);
    axi_wr(CTRL_OFS, 32'h0000_0001, r);
    // pin flop follows the control bit one edge later
    @(posedge aclk);
    chk("pdn", 32'(pdn_n), 32'h0000_0000);
    acc(1'b1, 2'h0, 8'h33, q);
    axi_wr(CTRL_OFS, 32'h0000_0000, r);
    acc(1'b0, 2'h0, 8'h00, q);
    chk("pdwr", 32'(q), 32'h0000_005a);
    irq_req <= 1'b1;
    repeat (6) @(posedge aclk);
    axi_rd(STATUS_OFS, s, r);
    chk("irq", 32'({s[2], irq_out}), 32'h0000_0003);
    irq_req <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("irq0", 32'(irq_out), 32'h0000_0000);
    axi_rd(8'h18, s, r);
    chk("rresp", 32'(r), 32'(RESP_SLVERR));
    chk("rdata0", s, 32'h0000_0000);
    axi_wr(8'h1c, 32'h0000_0000, r);
    chk("werr", 32'(r), 32'(RESP_SLVERR));
    // low byte strobe off: register keeps its value
    wstrb <= 4'h0;
    axi_wr(TIMING_OFS, 32'h0000_0005, r);
    wstrb <= 4'hf;
    axi_rd(TIMING_OFS, s, r);
    chk("wstrb", s, 32'h0000_0000);
    $display("sideband tests done");
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_basic;
    t_side;
    stop_test;
  end
endmodule
